/* include/srs_pkg.sv */
// Purpose: shared constants and types of the sleep and reset sequencer
// Assumes: 50 MHz reference clock, 32-bit register port
// Notes: times are in ns; cycle counts derive from them
package srs_pkg;
    // clock rate
    localparam int unsigned CLK_PERIOD_NS = 20;

    // register word offsets (byte addresses)
    localparam logic [7:0] REG_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] REG_PWR_REDUCE = 8'h04;
    localparam logic [7:0] REG_RST_CTRL = 8'h08;
    localparam logic [7:0] REG_RST_CAUSE = 8'h0c;
    localparam logic [7:0] REG_BOOT_CFG = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    // field positions
    localparam int unsigned SLP_EN_BIT = 0;
    localparam int unsigned SLP_MODE_LSB = 1;
    localparam int unsigned SWRST_BIT = 0;
    localparam int unsigned BOOTVEC_BIT = 0;
    localparam int unsigned STAT_SEQ_LSB = 0;
    localparam int unsigned STAT_PWR_LSB = 4;

    // reset sequence times
    localparam int unsigned T_RST_DELAY_NS = 1000;
    localparam int unsigned T_OSC_START_NS = 2000;
    localparam int unsigned T_OSC_CAL_NS = 2000;
    // least watchdog request, one 2 MHz period
    localparam int unsigned T_WDT_MIN_NS = 500;
    localparam int unsigned RST_DELAY_CYC = (T_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OSC_START_CYC = (T_OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OSC_CAL_CYC = (T_OSC_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDT_HOLD_CYC = (T_WDT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cpu halt after wake-up, in cycles
    localparam int unsigned WAKE_HALT_CYC = 4;
    localparam int unsigned CNT_W = 8;

    // reset vector locations (word addresses)
    localparam logic [15:0] RST_VEC_APP = 16'h0000;

    // sleep modes as written in the mode field
    typedef enum logic [2:0] {
        SLP_IDLE = 3'h0,
        SLP_PDOWN = 3'h1,
        SLP_PSAVE = 3'h2,
        SLP_STBY = 3'h3,
        SLP_ESTBY = 3'h4
    } srs_mode_t;

    typedef enum logic [2:0] {SEQ_HOLD, SEQ_DELAY, SEQ_OSC, SEQ_CAL, SEQ_RUN} srs_seq_t;
    typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_WAKE} srs_pwr_t;

    // reset cause flags, one per source
    typedef struct packed {
        logic sw;
        logic program_debug_interface;
        logic bod;
        logic wdt;
        logic ext;
        logic por;
    } srs_cause_t;

    // wake sources from asynchronous modules
    typedef struct packed {
        logic rtc;
        logic usb_resume;
        logic port_async;
        logic twi_addr;
    } srs_wake_t;
endpackage

/* src/srs_sync.sv */
// Purpose: two-flop synchroniser for a vector of asynchronous inputs
// Assumes: inputs are independent levels
// Notes: reset value is a parameter
`timescale 1ns/1ns
module srs_sync
    import srs_pkg::*;
#(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } srs_sync_state_t;

    srs_sync_state_t s;
    srs_sync_state_t next_s;

    // first stage is read only by the second
    always_comb
    begin
        next_s = s;
        if (i_ce)
        begin
            next_s.meta = i_async;
            next_s.stable = s.meta;
        end
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s <= {RST_VAL, RST_VAL};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_sync = s.stable;
endmodule

/* src/srs_sequencer.sv */
// Purpose: sleep mode control, clock gating and reset sequencing
// Assumes: i_ref_clk runs in every sleep mode; i_rst_n is power-on reset
// Notes: plain strobe register port, read data one cycle late
// How it works
// - any reset selects the 2 MHz internal oscillator
// - sleep only on the sleep instruction; software picks the mode
// - wake runs the waking handler, then resumes after sleep
// - higher-priority pending handlers run first
// - cpu halted four cycles after every wake-up
// - sleep keeps register file, sram and registers
// - reset in sleep resets fully, restarts at reset vector
// - idle stops cpu and nvm after programming; peripherals run
// - power-down stops all clocks, rtc too; the nvm clock here still runs while i_nvm_busy
// - power-down wakes only on twi match, async port, usb resume
// - power-save is power-down with rtc running and waking
// - standby is power-down with oscillators running
// - extended standby is power-save with oscillators running
// - power reduction bit freezes one peripheral clock
// - six reset sources: por, pin, watchdog, brownout, debug, software
// - reset asserts at once, holds until all sources release
// - reset tri-states pins, loads vector, resets i/o registers
// - reset leaves sram alone
// - reset vector 0, or boot section start when configured; here every reset clears boot_vec, so the vector after reset is 0
// - reset assertion needs no clock
// - sticky cause flag per source, cleared only by power-on
// - release: delay, oscillator start, calibration; new request restarts
// - software reset within two cycles of the write
// - pin reset lasts while the pin is low
// - watchdog request lasts at least one 2 MHz period
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module srs_sequencer
    import srs_pkg::*;
#(
    parameter int unsigned NPER = 8,
    parameter logic [15:0] BOOT_VEC = 16'h8000
)
(
    // clock, power-on reset, clock enable
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [31:0] o_rdata,
    // reset sources
    input wire logic i_ext_rst_n,
    input wire logic i_wdt_rst,
    input wire logic i_bod_rst,
    input wire logic i_pdi_rst,
    // processor and interrupt controller
    input wire logic i_sleep_instr,
    input wire logic i_irq_pending,
    input wire logic i_nvm_busy,
    // asynchronous wake sources
    input wire srs_wake_t i_wake,
    // reset outputs
    output logic o_core_rst_n,
    output logic o_io_hiz,
    output logic [15:0] o_rst_vec,
    output logic o_clk_sel_2m,
    // clock enables
    output logic o_cpu_clk_en,
    output logic o_nvm_clk_en,
    output logic [NPER-1:0] o_per_clk_en,
    output logic o_rtc_clk_en,
    output logic o_osc_run
);
    typedef struct packed {
        srs_seq_t seq;
        srs_pwr_t pwr;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] wdt_cnt;
        logic sw_req;
        logic slp_en;
        srs_mode_t mode;
        srs_mode_t act_mode;
        logic [NPER-1:0] prr;
        logic boot_vec;
        srs_cause_t cause;
        logic [31:0] rdata;
    } srs_top_state_t;

    localparam srs_cause_t CAUSE_POR = '{por: 1'b1, default: 1'b0};

    srs_top_state_t s;
    srs_top_state_t next_s;
    logic [3:0] rst_sync;
    srs_wake_t wake_sync;
    logic sync_req;
    logic wake_ok;
    logic mode_valid;

    // reset pins pass two flops before the sequence reads them
    srs_sync #(.W(4), .RST_VAL(4'h0)) u_rst_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async({~i_ext_rst_n, i_wdt_rst, i_bod_rst, i_pdi_rst}),
        .o_sync(rst_sync)
    );

    // wake requests from modules that run without a clock
    srs_sync #(.W(4), .RST_VAL(4'h0)) u_wake_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async(i_wake),
        .o_sync(wake_sync)
    );

    // synchronised request: restarts the release sequence
    assign sync_req = (rst_sync != '0) | (s.wdt_cnt != '0) | s.sw_req;

    // wake qualification per sleep mode
    always_comb
    begin
        wake_ok = wake_sync.twi_addr | wake_sync.port_async | wake_sync.usb_resume;
        case (s.act_mode)
            SLP_IDLE: wake_ok = i_irq_pending;
            SLP_PSAVE, SLP_ESTBY: wake_ok = wake_ok | wake_sync.rtc;
            SLP_PDOWN, SLP_STBY: wake_ok = wake_ok;
            default: wake_ok = wake_ok;
        endcase
    end

    assign mode_valid = (s.mode inside {SLP_IDLE, SLP_PDOWN, SLP_PSAVE, SLP_STBY, SLP_ESTBY});

    // next state
    always_comb
    begin
        next_s = s;
        next_s.rdata = '0;
        if (i_ce)
        begin
            // watchdog request stretched to the least length
            if (rst_sync[2])
            begin
                next_s.wdt_cnt = CNT_W'(WDT_HOLD_CYC);
            end
            else if (s.wdt_cnt != '0)
            begin
                next_s.wdt_cnt = s.wdt_cnt - 1'b1;
            end
            // sticky cause flags, set only; power-on reset clears them
            next_s.cause.ext = s.cause.ext | rst_sync[3];
            next_s.cause.wdt = s.cause.wdt | rst_sync[2];
            next_s.cause.bod = s.cause.bod | rst_sync[1];
            next_s.cause.program_debug_interface = s.cause.program_debug_interface | rst_sync[0];
            next_s.cause.sw = s.cause.sw | s.sw_req;
            if (sync_req)
            begin
                // i/o registers to initial values, flags kept
                next_s.seq = SEQ_HOLD;
                next_s.cnt = '0;
                next_s.sw_req = 1'b0;
                next_s.pwr = PWR_ACTIVE;
                next_s.slp_en = 1'b0;
                next_s.mode = SLP_IDLE;
                next_s.act_mode = SLP_IDLE;
                next_s.prr = '0;
                next_s.boot_vec = 1'b0;
            end
            else
            begin
                // release sequence: delay, oscillator start, calibration
                case (s.seq)
                    SEQ_HOLD:
                    begin
                        next_s.seq = SEQ_DELAY;
                        next_s.cnt = '0;
                    end
                    SEQ_DELAY:
                    begin
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == CNT_W'(RST_DELAY_CYC - 1))
                        begin
                            next_s.seq = SEQ_OSC;
                            next_s.cnt = '0;
                        end
                    end
                    SEQ_OSC:
                    begin
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == CNT_W'(OSC_START_CYC - 1))
                        begin
                            next_s.seq = SEQ_CAL;
                            next_s.cnt = '0;
                        end
                    end
                    SEQ_CAL:
                    begin
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == CNT_W'(OSC_CAL_CYC - 1))
                        begin
                            next_s.seq = SEQ_RUN;
                            next_s.cnt = '0;
                        end
                    end
                    SEQ_RUN:
                    begin
                        next_s.seq = SEQ_RUN;
                    end
                    default:
                    begin
                        next_s.seq = SEQ_HOLD;
                    end
                endcase

                // sleep control; gating clocks keeps all state intact
                case (s.pwr)
                    PWR_ACTIVE:
                    begin
                        if (s.seq == SEQ_RUN && i_sleep_instr && s.slp_en && mode_valid)
                        begin
                            next_s.pwr = PWR_SLEEP;
                            next_s.act_mode = s.mode;
                        end
                    end
                    PWR_SLEEP:
                    begin
                        if (wake_ok)
                        begin
                            next_s.pwr = PWR_WAKE;
                            next_s.cnt = '0;
                        end
                    end
                    PWR_WAKE:
                    begin
                        // pc resumes after the sleep instruction;
                        // interrupt controller orders pending handlers
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == CNT_W'(WAKE_HALT_CYC - 1))
                        begin
                            next_s.pwr = PWR_ACTIVE;
                            next_s.cnt = '0;
                        end
                    end
                    default:
                    begin
                        next_s.pwr = PWR_ACTIVE;
                    end
                endcase

                // register writes
                if (i_we)
                begin
                    case (i_addr)
                        REG_SLEEP_CTRL:
                        begin
                            next_s.slp_en = i_wdata[SLP_EN_BIT];
                            next_s.mode = srs_mode_t'(i_wdata[SLP_MODE_LSB +: 3]);
                        end
                        REG_PWR_REDUCE: next_s.prr = i_wdata[NPER-1:0];
                        REG_RST_CTRL: next_s.sw_req = i_wdata[SWRST_BIT];
                        REG_BOOT_CFG: next_s.boot_vec = i_wdata[BOOTVEC_BIT];
                        default: next_s.rdata = '0;
                    endcase
                end
            end

            // register reads, data in the following cycle
            if (i_re)
            begin
                case (i_addr)
                    REG_SLEEP_CTRL: next_s.rdata = 32'({s.mode, s.slp_en});
                    REG_PWR_REDUCE: next_s.rdata = 32'(s.prr);
                    REG_RST_CTRL: next_s.rdata = 32'(s.sw_req);
                    REG_RST_CAUSE: next_s.rdata = 32'(s.cause);
                    REG_BOOT_CFG: next_s.rdata = 32'(s.boot_vec);
                    REG_STATUS: next_s.rdata = 32'({s.pwr, 1'b0, s.seq}) << STAT_SEQ_LSB;
                    default: next_s.rdata = '0;
                endcase
            end
        end
        else
        begin
            next_s.rdata = s.rdata;
        end
    end

    // state register; only power-on reset clears the cause flags
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s <= '{seq: SEQ_HOLD, pwr: PWR_ACTIVE, mode: SLP_IDLE, act_mode: SLP_IDLE,
                   cause: CAUSE_POR, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // reset asserts straight from the sources, no clock needed
    assign o_core_rst_n = i_rst_n & i_ext_rst_n & ~i_wdt_rst & ~i_bod_rst & ~i_pdi_rst
                          & ~s.sw_req & ~sync_req & (s.seq == SEQ_RUN);
    // pins float while in reset; sram is not touched by this block
    assign o_io_hiz = ~o_core_rst_n;
    assign o_rst_vec = s.boot_vec ? BOOT_VEC : RST_VEC_APP;
    assign o_clk_sel_2m = ~o_core_rst_n;
    assign o_rdata = s.rdata;

    // clock gating per power state and sleep mode
    always_comb
    begin
        o_cpu_clk_en = (s.pwr == PWR_ACTIVE);
        o_nvm_clk_en = (s.pwr == PWR_ACTIVE) | i_nvm_busy;
        o_rtc_clk_en = 1'b1;
        o_osc_run = 1'b1;
        if (s.pwr == PWR_SLEEP)
        begin
            case (s.act_mode)
                SLP_IDLE:
                begin
                    o_rtc_clk_en = 1'b1;
                    o_osc_run = 1'b1;
                end
                SLP_PDOWN:
                begin
                    o_rtc_clk_en = 1'b0;
                    o_osc_run = 1'b0;
                end
                SLP_PSAVE:
                begin
                    o_rtc_clk_en = 1'b1;
                    o_osc_run = 1'b0;
                end
                SLP_STBY:
                begin
                    o_rtc_clk_en = 1'b0;
                    o_osc_run = 1'b1;
                end
                SLP_ESTBY:
                begin
                    o_rtc_clk_en = 1'b1;
                    o_osc_run = 1'b1;
                end
                default:
                begin
                    o_rtc_clk_en = 1'b0;
                    o_osc_run = 1'b0;
                end
            endcase
        end
    end

    // peripheral clock: off in deep sleep or when reduced
    genvar gi;
    generate
        for (gi = 0; gi < NPER; gi++)
        begin : g_per
            assign o_per_clk_en[gi] = ~s.prr[gi]
                                      & ((s.pwr != PWR_SLEEP) | (s.act_mode == SLP_IDLE));
        end
    endgenerate
endmodule

/* bench/srs_sequencer_chk.sv */
// Purpose: port assertions of the sequencer
// Assumes: one clock domain, i_rst_n is the asynchronous power-on reset
// Notes: bound into srs_sequencer below
`timescale 1ns/1ns
module srs_sequencer_chk
    import srs_pkg::*;
#(
    parameter int unsigned NPER = 8,
    parameter logic [15:0] BOOT_VEC = 16'h8000
)
(
    // clock, reset and register port
    input wire logic i_ref_clk, i_rst_n, i_ce, i_we, i_re,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] o_rdata,
    // reset sources and core side
    input wire logic i_ext_rst_n, i_wdt_rst, i_bod_rst, i_pdi_rst, i_sleep_instr, i_irq_pending, i_nvm_busy,
    input wire srs_wake_t i_wake,
    // outputs
    input wire logic o_core_rst_n, o_io_hiz, o_clk_sel_2m, o_cpu_clk_en, o_nvm_clk_en, o_rtc_clk_en, o_osc_run,
    input wire logic [15:0] o_rst_vec,
    input wire logic [NPER-1:0] o_per_clk_en
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // software reset write taken while the core runs
    sequence swrst_write_s;
        i_we && i_ce && i_addr == REG_RST_CTRL && i_wdata[SWRST_BIT] && o_core_rst_n;
    endsequence
    // cpu clock comes back with the core out of reset
    sequence cpu_restart_s;
        $rose(o_cpu_clk_en) && o_core_rst_n && $past(o_core_rst_n);
    endsequence
    // power-down sleep with no permitted wake source for three samples
    sequence pdown_quiet_s;
        !o_osc_run && !o_rtc_clk_en && i_wake[2:0] == 3'h0 && $past(i_wake[2:0]) == 3'h0
            && $past(i_wake[2:0], 2) == 3'h0;
    endsequence

    // reset outputs
    ext_holds_a: assert property (!i_ext_rst_n |-> !o_core_rst_n)
        else $error("pin reset ignored");
    pins_hiz_a: assert property (o_io_hiz == !o_core_rst_n)
        else $error("pins not tri-stated");
    osc_default_a: assert property (!o_core_rst_n |-> o_clk_sel_2m)
        else $error("no default oscillator");
    swrst_fast_a: assert property (swrst_write_s |=> !o_core_rst_n)
        else $error("software reset late");
    wdt_hold_a: assert property ($rose(i_wdt_rst) |-> !o_core_rst_n [*8])
        else $error("watchdog reset short");
    vec_choice_a: assert property (o_rst_vec == 16'h0000 || o_rst_vec == BOOT_VEC)
        else $error("bad reset vector");
    // sleep and clocks
    sleep_only_a: assert property ($fell(o_cpu_clk_en) && o_core_rst_n && $past(o_core_rst_n)
        |-> $past(i_sleep_instr))
        else $error("clock stop without sleep");
    wake_halt_a: assert property (cpu_restart_s |-> !$past(o_cpu_clk_en, 2) && !$past(o_cpu_clk_en, 3)
        && !$past(o_cpu_clk_en, 4))
        else $error("halt under four cycles");
    nvm_clk_a: assert property (o_nvm_clk_en == (o_cpu_clk_en || i_nvm_busy))
        else $error("nvm clock wrong");
    pdown_clocks_a: assert property (!o_osc_run |-> !o_cpu_clk_en && o_per_clk_en == '0)
        else $error("clock on with oscillator off");
    stby_clocks_a: assert property (!o_rtc_clk_en |-> !o_cpu_clk_en && o_per_clk_en == '0)
        else $error("clock on with rtc off");
    pdown_wake_a: assert property (pdown_quiet_s |=> !o_osc_run || !o_core_rst_n)
        else $error("power-down left unasked");
endmodule

bind srs_sequencer srs_sequencer_chk #(.NPER(NPER), .BOOT_VEC(BOOT_VEC)) u_chk (.i_ref_clk, .i_rst_n, .i_ce,
    .i_we, .i_re, .i_addr, .i_wdata, .o_rdata, .i_ext_rst_n, .i_wdt_rst, .i_bod_rst, .i_pdi_rst, .i_sleep_instr,
    .i_irq_pending, .i_nvm_busy, .i_wake, .o_core_rst_n, .o_io_hiz, .o_clk_sel_2m, .o_cpu_clk_en, .o_nvm_clk_en,
    .o_rtc_clk_en, .o_osc_run, .o_rst_vec, .o_per_clk_en);

/* bench/srs_core_model.sv */
// Purpose: processor core that issues the sleep instruction
// Assumes: the core executes only while clocked and out of reset
// Notes: one-cycle i_go asks for one sleep instruction
`timescale 1ns/1ns
module srs_core_model
(
    // clock and bench request
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic i_cpu_clk_en,
    input wire logic i_core_rst_n,
    // to the sequencer
    output logic o_sleep_instr
);
    initial o_sleep_instr = 1'b0;
    // a halted or reset core drops the request
    always @(posedge i_ref_clk)
    begin
        o_sleep_instr <= i_go && i_cpu_clk_en && i_core_rst_n && !o_sleep_instr;
    end
endmodule

/* bench/tb_srs_sequencer.sv */
// Purpose: bench for the sleep and reset sequencer
// Assumes: 50 MHz clock, clock enable held high
// Notes: integer model of modes and causes
`timescale 1ns/1ns
module tb_srs_sequencer
    import srs_pkg::*;
;
    localparam logic [15:0] BOOT = 16'h8000;
    localparam int SEQ = RST_DELAY_CYC + OSC_START_CYC + OSC_CAL_CYC;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_we = 1'b0, i_re = 1'b0, go = 1'b0;
    logic i_ext_rst_n = 1'b1, i_wdt_rst = 1'b0, i_bod_rst = 1'b0, i_pdi_rst = 1'b0;
    logic i_irq_pending = 1'b0, i_nvm_busy = 1'b0, i_sleep_instr;
    logic [7:0] i_addr = 8'h00, prr;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    srs_wake_t i_wake = '0;
    logic o_core_rst_n, o_io_hiz, o_clk_sel_2m, o_cpu_clk_en, o_nvm_clk_en, o_rtc_clk_en, o_osc_run;
    logic [15:0] o_rst_vec;
    logic [7:0] o_per_clk_en;
    int fail_count = 0, samples_checked = 0, seed = 57244, cause = 1, n, m, w;
    int modes [6] = '{0, 1, 2, 3, 4, 1};
    int wbit [6] = '{-1, 0, 3, 1, 3, 2};

    srs_sequencer #(.NPER(8), .BOOT_VEC(BOOT)) dut (.i_ref_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_we,
        .i_re, .o_rdata, .i_ext_rst_n, .i_wdt_rst, .i_bod_rst, .i_pdi_rst, .i_sleep_instr, .i_irq_pending,
        .i_nvm_busy, .i_wake, .o_core_rst_n, .o_io_hiz, .o_rst_vec, .o_clk_sel_2m, .o_cpu_clk_en, .o_nvm_clk_en,
        .o_per_clk_en, .o_rtc_clk_en, .o_osc_run);
    srs_core_model u_core (.i_ref_clk, .i_go(go), .i_cpu_clk_en(o_cpu_clk_en), .i_core_rst_n(o_core_rst_n),
        .o_sleep_instr(i_sleep_instr));

    // clock and hang guard
    initial forever #10 i_ref_clk = ~i_ref_clk;
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        fail_count++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_len(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_we <= 1'b1;
        @(posedge i_ref_clk);
        i_we <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_ref_clk);
        i_re <= 1'b0;
        @(negedge i_ref_clk);
        check(what, exp, o_rdata);
    endtask
    // cycles until core release
    task automatic release_len(input int lo, input int hi);
        n = 0;
        while (o_core_rst_n !== 1'b1 && n < 2000)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        check_len("release", lo, hi, n);
    endtask
    task automatic sleep_in(input int mode);
        wr(REG_SLEEP_CTRL, 32'(mode * 2 + (mode >= 0)));
        @(posedge i_ref_clk);
        go <= 1'b1;
        i_nvm_busy <= 1'($random(seed));
        @(posedge i_ref_clk);
        go <= 1'b0;
        repeat (3) @(negedge i_ref_clk);
    endtask

    initial
    begin
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        release_len(SEQ, SEQ + 6);
        rd("cause", REG_RST_CAUSE, 32'(cause));
        rd("status", REG_STATUS, 32'h4);
        rd("unmapped", 8'h20, 32'h0);
        check("vector", 32'h0, o_rst_vec);
        wr(REG_BOOT_CFG, 32'h1);
        @(negedge i_ref_clk);
        check("boot vector", {16'h0, BOOT}, o_rst_vec);
        prr = 8'($random(seed));
        wr(REG_PWR_REDUCE, {24'h0, prr});
        rd("reduce", REG_PWR_REDUCE, {24'h0, prr});
        check("per gating", {24'h0, ~prr}, o_per_clk_en);
        // refused: enable clear, bad mode
        sleep_in(-1);
        check("no enable", 32'h1, o_cpu_clk_en);
        sleep_in(5);
        check("bad mode", 32'h1, o_cpu_clk_en);
        for (int k = 0; k < 6; k++)
        begin
            sleep_in(modes[k]);
            check("cpu clock", 32'h0, o_cpu_clk_en);
            check("nvm clock", 32'(i_nvm_busy), o_nvm_clk_en);
            check("per clock", modes[k] == 0 ? {24'h0, ~prr} : 32'h0, o_per_clk_en);
            check("rtc clock", 32'(modes[k] != 1 && modes[k] != 3), o_rtc_clk_en);
            check("osc run", 32'(modes[k] != 1 && modes[k] != 2), o_osc_run);
            // sources this mode must ignore
            if (modes[k] != 0)
            begin
                @(posedge i_ref_clk);
                i_irq_pending <= 1'b1;
                i_wake.rtc <= (modes[k] == 1 || modes[k] == 3);
                repeat (8) @(negedge i_ref_clk);
                check("stray wake", 32'h0, o_cpu_clk_en);
            end
            @(posedge i_ref_clk);
            w = wbit[k];
            if (w < 0)
                i_irq_pending <= 1'b1;
            else
                i_wake[w] <= 1'b1;
            m = 0;
            while (o_cpu_clk_en !== 1'b1 && m < 40)
            begin
                @(negedge i_ref_clk);
                m++;
            end
            check_len("wake", WAKE_HALT_CYC + 1, WAKE_HALT_CYC + 7, m);
            @(posedge i_ref_clk);
            i_irq_pending <= 1'b0;
            i_wake <= '0;
        end
        // software reset
        wr(REG_RST_CTRL, 32'h1);
        @(negedge i_ref_clk);
        check("sw reset", 32'h0, o_core_rst_n);
        release_len(SEQ, SEQ + 6);
        cause = cause | 32;
        rd("reduce cleared", REG_PWR_REDUCE, 32'h0);
        // pin and brownout overlap
        @(posedge i_ref_clk);
        i_ext_rst_n <= 1'b0;
        i_bod_rst <= 1'b1;
        repeat (20) @(posedge i_ref_clk);
        i_ext_rst_n <= 1'b1;
        repeat (20) @(negedge i_ref_clk);
        check("overlap", 32'h0, o_core_rst_n);
        @(posedge i_ref_clk);
        i_bod_rst <= 1'b0;
        release_len(SEQ, SEQ + 6);
        cause = cause | 2 | 8;
        // debug reset, brownout restarts
        @(posedge i_ref_clk);
        i_pdi_rst <= 1'b1;
        repeat (5) @(posedge i_ref_clk);
        i_pdi_rst <= 1'b0;
        repeat (100) @(posedge i_ref_clk);
        i_bod_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_bod_rst <= 1'b0;
        release_len(SEQ, SEQ + 8);
        cause = cause | 16;
        // short watchdog request stretched
        @(posedge i_ref_clk);
        i_wdt_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_wdt_rst <= 1'b0;
        release_len(SEQ + WDT_HOLD_CYC, SEQ + WDT_HOLD_CYC + 10);
        cause = cause | 4;
        // pin reset in power-down
        sleep_in(1);
        @(posedge i_ref_clk);
        i_ext_rst_n <= 1'b0;
        repeat (5) @(negedge i_ref_clk);
        check("sleep reset", 32'h0, o_core_rst_n);
        check("clocks back", 32'h1, o_cpu_clk_en);
        @(posedge i_ref_clk);
        i_ext_rst_n <= 1'b1;
        release_len(SEQ, SEQ + 6);
        rd("status after", REG_STATUS, 32'h4);
        rd("all causes", REG_RST_CAUSE, 32'(cause));
        // power-on clears flags
        @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        release_len(SEQ, SEQ + 6);
        rd("por cause", REG_RST_CAUSE, 32'h1);
        end_of_test();
    end
endmodule
